// ### nand_host_pkg.sv
// Purpose: shared constants and carrier types for the nand host sequencer
// Assumes: 100 MHz sys_clk, byte-wide flash bus
// Notes: times are kept in their own units; cycle counts derive from them
package nand_host_pkg;
	localparam int CLK_MHZ = 100;
	localparam int CLK_NS = 10;
	// pin-level timing in ns
	localparam int WRITE_CYCLE_NS = 25;
	localparam int READ_CYCLE_NS = 25;
	localparam int STROBE_TO_BUSY_DELAY_NS = 100;
	localparam int ADDRESS_TO_DATA_DELAY_NS = 70;
	localparam int WE_HIGH_TO_RE_LOW_NS = 60;
	// busy maxima in us, used as watchdog limits
	localparam int ARRAY_READ_TIME_US = 25;
	localparam int CACHE_READ_BUSY_TIME_US = 25;
	localparam int PAGE_PROGRAM_TIME_US = 700;
	localparam int CACHE_PROGRAM_BUSY_TIME_US = 700;
	localparam int FEATURE_BUSY_TIME_US = 1;
	localparam int LOCKED_BLOCK_BUSY_TIME_US = 3;
	localparam int PROTECTED_OTP_BUSY_TIME_US = 30;
	localparam int DUAL_PLANE_BUSY_TIME_US = 1;
	// final cache page may need two page times
	localparam int FINAL_PAGE_PROGRAM_TIME_US = 2 * PAGE_PROGRAM_TIME_US;
	// least times round up to cycles
	localparam int WC_CYC = (WRITE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_CYC = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (STROBE_TO_BUSY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADL_CYC = (ADDRESS_TO_DATA_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHR_CYC = (WE_HIGH_TO_RE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_WC = (WC_CYC + 1) / 2;
	localparam int PARTIAL_PROGRAM_LIMIT = 4;
	localparam int LAST_COLUMN = 2111;
	localparam int ID_BYTES = 5;
	// command codes
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] ID_ADDR_JEDEC = 8'h00;
	localparam logic [7:0] ID_ADDR_ONFI = 8'h20;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam int STATUS_READY_BIT = 5;
	// flops between the ready/busy pin and the logic that reads it
	localparam int SYNC_CYC = 2;
	localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	// cycle kinds the user queues
	typedef enum logic [2:0] {
		CY_CMD = 3'b000,
		CY_ADDR = 3'b001,
		CY_WDATA = 3'b010,
		CY_RDATA = 3'b011,
		CY_WAIT = 3'b100
	} cycle_kind_t;
	typedef struct packed {
		cycle_kind_t kind;
		logic [7:0] data;
		logic [19:0] limit_us;
	} cycle_req_t;
	typedef struct packed {
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic ce_n;
	} strobe_t;
endpackage

// ### busy_watch.sv
// Purpose: microsecond timer that bounds a busy wait
// Assumes: start is a one-cycle pulse, limit sampled at start
// Notes: expires one tick after limit microseconds have elapsed
`timescale 1ns/10ps
module busy_watch #(
	parameter int CYC_PER_US = nand_host_pkg::CLK_MHZ
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic start, // begin counting
	input wire logic stop, // abandon count
	input wire logic [19:0] limit_us, // bound in microseconds
	output logic expired // level, set once limit passes
);
	logic [6:0] sub_ff;
	logic [19:0] us_ff;
	logic [19:0] lim_ff;
	logic run_ff;
	wire tick = run_ff && (sub_ff == 7'(CYC_PER_US - 1));
	// prescaler to whole microseconds
	always_ff @(posedge sys_clk) begin
		if (rst || start || stop) begin
			sub_ff <= 7'h00;
		end else if (run_ff) begin
			sub_ff <= tick ? 7'h00 : sub_ff + 7'h01;
		end
	end
	// microsecond count and latch of the bound
	always_ff @(posedge sys_clk) begin
		if (rst || stop) begin
			run_ff <= 1'b0;
			us_ff <= 20'h00000;
			lim_ff <= 20'h00000;
		end else if (start) begin
			run_ff <= 1'b1;
			us_ff <= 20'h00000;
			lim_ff <= limit_us;
		end else if (tick) begin
			us_ff <= us_ff + 20'h00001;
		end
	end
	assign expired = run_ff && (us_ff > lim_ff);
endmodule // busy_watch

// ### nand_host.sv
// Purpose: host sequencer driving an asynchronous byte-wide nand flash
// Assumes: user queues one bus cycle at a time; ready_busy_n from a pin
// Notes: busy waits are bounded by the worst case the caller supplies
`timescale 1ns/10ps
module nand_host (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, high
	input wire nand_host_pkg::cycle_req_t req, // requested bus cycle
	input wire logic req_valid, // request present
	output logic req_ready, // request taken this cycle
	output logic [7:0] rdata_ff, // byte read from the flash
	output logic rdata_valid_ff, // one-cycle pulse with rdata_ff
	output logic timeout_ff, // pulse: busy outlasted the bound
	output logic page_prog_over_ff, // level: too many partial programs
	input wire logic wp_hold_n, // user write-protect request, low protects
	output logic idle, // sequencer idle and device ready
	output nand_host_pkg::strobe_t strobes_ff, // cle, ale, we_n, re_n, ce_n
	output logic wp_n_ff, // write-protect pin, low protects
	output logic [7:0] data_lines_o, // data lines out
	output logic data_lines_oe, // data lines driven while high
	input wire logic [7:0] data_lines_i, // data lines in
	input wire logic ready_busy_n // ready/busy pin, low busy
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WLOW = 3'b001,
		ST_WHIGH = 3'b010,
		ST_RLOW = 3'b011,
		ST_RHIGH = 3'b100,
		ST_GAP = 3'b101,
		ST_BUSY = 3'b110
	} seq_state_t;
	seq_state_t state_ff, nxt_state;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic rb_s1_ff, rb_s2_ff;
	logic [7:0] din_s1_ff, din_s2_ff;
	nand_host_pkg::cycle_req_t cur_ff;
	nand_host_pkg::cycle_kind_t last_kind_ff;
	logic [2:0] part_cnt_ff;
	logic wd_start, wd_expired;
	//////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		rb_s1_ff <= ready_busy_n;
		rb_s2_ff <= rb_s1_ff;
		din_s1_ff <= data_lines_i;
		din_s2_ff <= din_s1_ff;
	end
	//////////////////////////////////////////////////////////////////////
	// decode of the pending request
	wire is_cmd = (req.kind == nand_host_pkg::CY_CMD);
	wire is_wait = (req.kind == nand_host_pkg::CY_WAIT);
	wire is_rd = (req.kind == nand_host_pkg::CY_RDATA);
	wire is_wdata = (req.kind == nand_host_pkg::CY_WDATA);
	// first data after address needs the address-to-data gap
	wire need_adl = is_wdata &&
		(last_kind_ff == nand_host_pkg::CY_ADDR);
	wire take = (state_ff == ST_IDLE) && req_valid;
	assign req_ready = take;
	// idle only when the pin says ready: dependent commands wait
	assign idle = (state_ff == ST_IDLE) && rb_s2_ff;
	wire gap_done = (cnt_ff == 8'h00);
	wire rb_ready = rb_s2_ff;
	assign wd_start = take && is_wait;
	//////////////////////////////////////////////////////////////////////
	// next-state decode
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = (cnt_ff == 8'h00) ? 8'h00 : cnt_ff - 8'h01;
		case (state_ff)
			ST_IDLE: begin
				if (take && is_wait) begin
					// busy started by data input has no gap of its own, so the
					// pin is ignored until it can have fallen and passed the sync
					nxt_state = ST_BUSY;
					nxt_cnt = 8'(nand_host_pkg::WB_CYC + nand_host_pkg::SYNC_CYC);
				end else if (take && is_rd) begin
					nxt_state = ST_RLOW;
					nxt_cnt = 8'(nand_host_pkg::HALF_WC - 1);
				end else if (take && need_adl) begin
					nxt_state = ST_GAP;
					nxt_cnt = 8'(nand_host_pkg::ADL_CYC - nand_host_pkg::WC_CYC);
				end else if (take) begin
					nxt_state = ST_WLOW;
					nxt_cnt = 8'(nand_host_pkg::HALF_WC - 1);
				end
			end
			ST_GAP: begin
				if (gap_done) begin
					nxt_state = (cur_ff.kind == nand_host_pkg::CY_WDATA) ? ST_WLOW : ST_IDLE;
					nxt_cnt = 8'(nand_host_pkg::HALF_WC - 1);
				end
			end
			ST_WLOW: begin
				if (gap_done) begin
					nxt_state = ST_WHIGH;
					nxt_cnt = 8'(nand_host_pkg::HALF_WC - 1);
				end
			end
			ST_WHIGH: begin
				if (gap_done && cur_ff.kind == nand_host_pkg::CY_CMD) begin
					// hold off after every command for the strobe-to-busy window
					nxt_state = ST_GAP;
					nxt_cnt = 8'(nand_host_pkg::WB_CYC);
				end else if (gap_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_RLOW: begin
				if (gap_done) begin
					nxt_state = ST_RHIGH;
					nxt_cnt = 8'(nand_host_pkg::HALF_WC - 1);
				end
			end
			ST_RHIGH: begin
				if (gap_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_BUSY: begin
				// leave on ready, or on the caller's worst-case bound
				if ((rb_ready && gap_done) || wd_expired) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end
	//////////////////////////////////////////////////////////////////////
	// sequencer registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			cur_ff <= '0;
			last_kind_ff <= nand_host_pkg::CY_WAIT;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			if (take) begin
				cur_ff <= req;
				last_kind_ff <= req.kind;
			end
		end
	end
	//////////////////////////////////////////////////////////////////////
	// pin drive from state; all outputs registered
	wire we_low = (nxt_state == ST_WLOW);
	// latch enables and data hold through the high half, past the rising strobe
	wire we_cyc = we_low || (nxt_state == ST_WHIGH);
	wire re_low = (nxt_state == ST_RLOW);
	wire cyc_cmd = (take ? is_cmd : cur_ff.kind == nand_host_pkg::CY_CMD);
	wire cyc_addr = (take ? req.kind == nand_host_pkg::CY_ADDR :
		cur_ff.kind == nand_host_pkg::CY_ADDR);
	wire [7:0] out_byte = take ? req.data : cur_ff.data;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strobes_ff <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, ce_n: 1'b1};
			data_lines_o <= 8'h00;
			data_lines_oe <= 1'b0;
		end else begin
			strobes_ff.cle <= we_cyc && cyc_cmd;
			strobes_ff.ale <= we_cyc && cyc_addr;
			strobes_ff.we_n <= !we_low;
			strobes_ff.re_n <= !re_low;
			strobes_ff.ce_n <= (nxt_state == ST_IDLE) && !req_valid;
			data_lines_o <= out_byte;
			data_lines_oe <= we_cyc;
		end
	end
	// write protect changes only while idle and ready
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wp_n_ff <= 1'b0;
		end else if (idle && !req_valid) begin
			wp_n_ff <= wp_hold_n;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// read capture at the rising read strobe; id and status are plain reads
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
			rdata_valid_ff <= 1'b0;
		end else begin
			rdata_valid_ff <= (state_ff == ST_RHIGH) && gap_done;
			if ((state_ff == ST_RHIGH) && gap_done) begin
				rdata_ff <= din_s2_ff;
			end
		end
	end
	//////////////////////////////////////////////////////////////////////
	// busy watchdog; caller passes the worst time of the operation
	busy_watch u_watch (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(wd_start),
		.stop(state_ff != ST_BUSY && !wd_start),
		.limit_us(req.limit_us),
		.expired(wd_expired)
	);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timeout_ff <= 1'b0;
		end else begin
			timeout_ff <= (state_ff == ST_BUSY) && wd_expired && !rb_ready;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// partial program guard: counts program confirms, erase clears
	wire prog_cmd = take && is_cmd && (req.data == nand_host_pkg::CMD_PROGRAM_CONFIRM);
	wire erase_cmd = take && is_cmd && (req.data == nand_host_pkg::CMD_ERASE_CONFIRM);
	always_ff @(posedge sys_clk) begin
		if (rst || erase_cmd) begin
			part_cnt_ff <= 3'h0;
		end else if (prog_cmd && part_cnt_ff != 3'h7) begin
			part_cnt_ff <= part_cnt_ff + 3'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			page_prog_over_ff <= 1'b0;
		end else begin
			page_prog_over_ff <= (part_cnt_ff > 3'(nand_host_pkg::PARTIAL_PROGRAM_LIMIT));
		end
	end
	// column count for data input is the caller's; 2111 is the final column
	//////////////////////////////////////////////////////////////////////
	// checks
	a_busy_exit_ready: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_BUSY && rb_ready && gap_done) |=> state_ff == ST_IDLE)
		else $error("busy state did not end on ready");
	a_cmd_gap_wb: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_WHIGH && gap_done && cur_ff.kind == nand_host_pkg::CY_CMD)
		|=> state_ff == ST_GAP [*8])
		else $error("command not followed by busy gap");
	a_wp_steady: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff != ST_IDLE) |=> $stable(wp_n_ff))
		else $error("write protect moved during operation");
	a_read_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_RHIGH && gap_done) |=> rdata_valid_ff && strobes_ff.re_n)
		else $error("read byte not delivered");
	a_timeout_cause: assert property (@(posedge sys_clk) disable iff (rst)
		timeout_ff |-> $past(wd_expired) && $past(state_ff) == ST_BUSY)
		else $error("timeout without expired bound");
	a_over_limit: assert property (@(posedge sys_clk) disable iff (rst)
		page_prog_over_ff |-> $past(part_cnt_ff) > 3'h4)
		else $error("partial program flag wrong");
	a_adl_gap: assert property (@(posedge sys_clk) disable iff (rst)
		(take && need_adl) |=> state_ff == ST_GAP)
		else $error("missing address to data gap");
	a_oe_write: assert property (@(posedge sys_clk) disable iff (rst)
		!strobes_ff.we_n |-> data_lines_oe)
		else $error("write strobe without driven data");
endmodule // nand_host

// ### flash_model.sv
// Purpose: behavioural flash device facing the nand host
// Assumes: strobes change on the host clock, byte-wide bus
// Notes: busy times are fixed inside the worst cases while slow is low; no block lock or otp
`timescale 1ns/10ps
module flash_model #(
	parameter logic [39:0] ID_VAL = 40'h0 // identifier bytes, byte 0 lowest
) (
	input wire nand_host_pkg::strobe_t strobes, // cle, ale, we_n, re_n, ce_n
	input wire logic [7:0] bus_in, // resolved data lines
	input wire logic slow, // fix every busy at 3000 ns, past a 1 us host bound
	output logic [7:0] data_out, // byte the device drives
	output logic ready_busy_n // low while busy
);
	logic [7:0] mem [0:2111];
	logic [11:0] col = 12'h000;
	logic [2:0] acnt = 3'h0;
	logic [1:0] mode = 2'h0;
	logic [2:0] idx = 3'h0;
	logic [2:0] fcnt = 3'h0;
	initial begin
		ready_busy_n = 1'b1;
		data_out = 8'h00;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// busy starts a little after the strobe, well inside the allowed delay
	task automatic go_busy(input int ns);
		#50;
		ready_busy_n = 1'b0;
		#(slow ? 3000 : ns);
		ready_busy_n = 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// latch on the rising write strobe; a busy wait blocks further latches
	always @(posedge strobes.we_n) begin
		if (!strobes.ce_n && strobes.cle) begin
			acnt = 3'h0;
			case (bus_in)
				8'h90: mode = 2'h1;
				8'h70: mode = 2'h2;
				8'hef: fcnt = 3'h4;
				8'h30: go_busy(2000);
				8'h31: go_busy(1000);
				8'h15: go_busy(3000);
				8'h11: go_busy(600);
				8'h10, 8'hd0: go_busy(4000);
				default: mode = 2'h0;
			endcase
			idx = 3'h0;
		end else if (!strobes.ce_n && strobes.ale) begin
			if (acnt == 3'h0) col[7:0] = bus_in;
			if (acnt == 3'h1) col[11:8] = bus_in[3:0];
			acnt = acnt + 3'h1;
		end else if (!strobes.ce_n && fcnt != 3'h0) begin
			fcnt = fcnt - 3'h1;
			if (fcnt == 3'h0) go_busy(500);
		end else if (!strobes.ce_n) begin
			if (col <= 12'd2111) mem[col] = bus_in;
			col = col + 12'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// output byte chosen on the falling read strobe; inverse when released
	// released bus flips the last byte, so a host that samples late sees garbage
	always @(posedge strobes.re_n) data_out = ~data_out;
	always @(negedge strobes.re_n) begin
		if (!strobes.ce_n) begin
			case (mode)
				2'h1: data_out = ID_VAL[idx*8 +: 8];
				2'h2: data_out = {1'b0, ready_busy_n, ready_busy_n, 5'h00};
				default: data_out = mem[col];
			endcase
			idx = idx + 3'h1;
			col = col + 12'h001;
		end
	end
endmodule // flash_model

// ### nand_host_tb_top.sv
// Purpose: self-checking bench for the nand host sequencer
// Assumes: flash_model on the far side, 100 MHz sys_clk
// Notes: expected bytes and timeouts queue up; a watcher retires them
`timescale 1ns/10ps
module nand_host_tb_top;
	localparam logic [39:0] ID_VAL = 40'h5e4d3c2b1a; // arbitrary identifier bytes
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	nand_host_pkg::cycle_req_t req = '0;
	logic req_valid = 1'b0;
	logic wp_hold_n = 1'b1;
	logic slow = 1'b0;
	logic req_ready, rdata_valid_ff, timeout_ff, page_prog_over_ff, idle, wp_n_ff;
	logic data_lines_oe, ready_busy_n, was_ale, was_cle;
	logic [7:0] rdata_ff, data_lines_o, dev_out, bus, w0, w1;
	logic [31:0] seed = 32'h978f;
	logic [31:0] r;
	logic [16:0] note;
	logic [16:0] notes [$];
	nand_host_pkg::strobe_t strobes_ff;
	realtime t_addr = 0;
	realtime t_cmd = 0;
	int fails = 0;
	int checks = 0;
	assign bus = data_lines_oe ? data_lines_o : dev_out;
	always #5 sys_clk = ~sys_clk;
	nand_host i_nand_host (.sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rdata_ff(rdata_ff), .rdata_valid_ff(rdata_valid_ff),
		.timeout_ff(timeout_ff), .page_prog_over_ff(page_prog_over_ff),
		.wp_hold_n(wp_hold_n), .idle(idle), .strobes_ff(strobes_ff), .wp_n_ff(wp_n_ff),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .data_lines_i(bus),
		.ready_busy_n(ready_busy_n));
	flash_model #(.ID_VAL(ID_VAL)) i_flash_model (.strobes(strobes_ff), .bus_in(bus),
		.slow(slow), .data_out(dev_out), .ready_busy_n(ready_busy_n));
	////////////////////////////////////////////////////////////////////////
	// xorshift source and the two compare tasks
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task check_byte(input logic [7:0] exp, input logic [7:0] mask, input logic [7:0] got);
		checks++;
		if (((got ^ exp) & mask) !== 8'h00) begin
			fails++;
			$display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task check_flag(input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// one request, held until the edge that takes it; bounded
	task op(input nand_host_pkg::cycle_kind_t k, input logic [7:0] d, input logic [19:0] l);
		int n;
		n = 0;
		@(posedge sys_clk);
		r = rnd();
		req <= '{kind: k, data: d, limit_us: l};
		req_valid <= 1'b1;
		wp_hold_n <= r[0];
		do begin
			@(negedge sys_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			check_flag(1'b1, 1'b0);
			complete_run();
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask
	task cmd(input logic [7:0] d); op(nand_host_pkg::CY_CMD, d, 20'h0); endtask
	task adr(input logic [7:0] d); op(nand_host_pkg::CY_ADDR, d, 20'h0); endtask
	task wr(input logic [7:0] d); op(nand_host_pkg::CY_WDATA, d, 20'h0); endtask
	task rd(input logic [7:0] e, input logic [7:0] m);
		notes.push_back({1'b0, m, e});
		op(nand_host_pkg::CY_RDATA, 8'h00, 20'h0);
	endtask
	task addr5(input logic [11:0] c);
		adr(c[7:0]);
		adr({4'h0, c[11:8]});
		repeat (3) adr(8'h00);
	endtask
	// wait on busy, then on idle; a late device must raise the timeout
	task wt(input logic [19:0] l, input logic to);
		int n;
		if (to) notes.push_back({1'b1, 16'h0000});
		op(nand_host_pkg::CY_WAIT, 8'h00, l);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (idle !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			check_flag(1'b1, 1'b0);
			complete_run();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// watcher retires the oldest note for each result pulse
	always @(posedge sys_clk) begin
		if (rdata_valid_ff === 1'b1 || timeout_ff === 1'b1) begin
			if (notes.size() == 0) begin
				check_flag(1'b0, 1'b1);
			end else begin
				note = notes.pop_front();
				check_flag(note[16], timeout_ff);
				check_byte(note[7:0], note[15:8], rdata_ff);
			end
		end
	end
	// kind of cycle is read at the falling strobe, when cle and ale are set
	always @(negedge strobes_ff.we_n) begin
		if (t_cmd > 0) check_flag(1'b1, ($realtime - t_cmd) >= 100.0);
		t_cmd = 0;
		was_ale = strobes_ff.ale;
		was_cle = strobes_ff.cle;
	end
	always @(posedge strobes_ff.we_n) begin
		if (was_cle) t_cmd = $realtime;
		if (was_ale) t_addr = $realtime;
		else if (!was_cle && t_addr > 0) begin
			check_flag(1'b1, ($realtime - t_addr) >= 70.0);
			t_addr = 0;
		end
	end
	// write protect must not move while the device is busy
	always @(wp_n_ff) if (ready_busy_n === 1'b0) check_flag(1'b0, 1'b1);
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (int a = 0; a < 2; a++) begin
			cmd(nand_host_pkg::CMD_READ_ID);
			adr(a ? nand_host_pkg::ID_ADDR_ONFI : nand_host_pkg::ID_ADDR_JEDEC);
			for (int b = 0; b < 5; b++) rd(ID_VAL[b*8 +: 8], 8'hff);
		end
		// feature store: late device first, then a prompt one
		for (int s = 1; s >= 0; s--) begin
			slow = s[0];
			cmd(8'hef);
			adr(8'h01);
			repeat (4) wr(8'h5a);
			wt(20'd1, s[0]);
		end
		// program the last two columns, read them back, then status
		r = rnd();
		w0 = r[7:0];
		w1 = r[15:8];
		cmd(8'h80);
		addr5(12'd2110);
		wr(w0);
		wr(w1);
		cmd(8'h10);
		wt(20'd700, 1'b0);
		cmd(8'h00);
		addr5(12'd2110);
		cmd(8'h30);
		wt(20'd25, 1'b0);
		rd(w0, 8'hff);
		rd(w1, 8'hff);
		cmd(nand_host_pkg::CMD_STATUS);
		rd(8'h20, 8'h20);
		cmd(8'h15);
		wt(20'd700, 1'b0);
		cmd(8'h11);
		wt(20'd1, 1'b0);
		cmd(8'h31);
		wt(20'd25, 1'b0);
		// partial-program count across an erase boundary
		for (int p = 0; p < 7; p++) begin
			if (p == 0 || p == 6) begin
				cmd(8'h60);
				repeat (3) adr(8'h00);
				cmd(8'hd0);
			end else cmd(8'h10);
			wt(20'd700, 1'b0);
			check_flag(p == 5, page_prog_over_ff);
		end
		check_flag(1'b1, notes.size() == 0);
		complete_run();
	end
endmodule // nand_host_tb_top
